//--- hdl/comc_pkg.sv
// constants and types for the cache operating mode control block
// assumes a single core clock and a synchronous active-high reset
package comc_pkg;

  localparam int CTRL_W = 32;
  localparam int CD_BIT = 30;
  localparam int NW_BIT = 29;
  localparam logic [CTRL_W-1:0] CTRL_RST = 32'h6000_0000;
  localparam logic [15:0] FAULT_CODE = 16'h0000;
  localparam logic NEW_FAMILY_DEF = 1'b1;

  typedef enum logic [1:0] {
    COMC_NORMAL,
    COMC_NOFILL,
    COMC_INVALID,
    COMC_NONCOH
  } comc_mode_t;

  typedef enum logic [1:0] {
    ST_I = 2'h0,
    ST_S = 2'h1,
    ST_E = 2'h2,
    ST_M = 2'h3
  } comc_line_t;

endpackage : comc_pkg

//--- hdl/comc_if.sv
// carrier between the mode register and the access decoder
// assumes both ends share the core clock
`timescale 1ns/1ps
interface comc_if;
  import comc_pkg::*;
  logic cache_disable_flag;
  logic write_policy_flag;
  modport regs (output cache_disable_flag, output write_policy_flag);
  modport dec (input cache_disable_flag, input write_policy_flag);
endinterface : comc_if

//--- hdl/comc_ctrl_reg.sv
// primary control register holding the cache flags
// assumes writes arrive as one-cycle strobes from the core
`timescale 1ns/1ps
module comc_ctrl_reg
  import comc_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic sys_rst, // sync reset
  input wire logic wr_en, // write strobe
  input wire logic [CTRL_W-1:0] wr_data, // write value
  input wire logic new_family, // no-fill replaces non-coherent
  output logic [CTRL_W-1:0] ctrl_q, // register value
  output logic fault, // protection fault pulse
  comc_if.regs flags // decoded flags
);
  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic fault_r, fault_nxt;
  logic bad;

  always_comb begin
    bad = !wr_data[CD_BIT] && wr_data[NW_BIT];
    ctrl_nxt = ctrl_r;
    fault_nxt = 1'b0;
    if (wr_en && bad) begin
      fault_nxt = 1'b1;
    end else if (wr_en) begin
      ctrl_nxt = wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r <= CTRL_RST;
      fault_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      fault_r <= fault_nxt;
    end
  end

  assign ctrl_q = ctrl_r;
  assign fault = fault_r;
  assign flags.cache_disable_flag = ctrl_r[CD_BIT];
  assign flags.write_policy_flag = ctrl_r[NW_BIT] && !(new_family && ctrl_r[CD_BIT]) ;

  chk_bad_write_kept: assert property (@(posedge clk) disable iff (sys_rst)
    wr_en && !wr_data[CD_BIT] && wr_data[NW_BIT] |=> fault && ctrl_r == $past(ctrl_r))
    else $error("invalid flag write changed register");
  chk_fault_raised: assert property (@(posedge clk) disable iff (sys_rst)
    fault |-> $past(wr_en) && $past(wr_data[NW_BIT]) && !$past(wr_data[CD_BIT]))
    else $error("fault without invalid write");
endmodule : comc_ctrl_reg

//--- hdl/comc_mode_ctrl.sv
// cache operating mode control: decodes flags into per-access policy
// assumes the core presents one lookup per cycle with line state and hit
`timescale 1ns/1ps
module comc_mode_ctrl
  import comc_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic sys_rst, // sync reset
  input wire logic new_family, // newer family strap
  input wire logic ctrl_wr, // control register write
  input wire logic [CTRL_W-1:0] ctrl_wdata, // control write data
  output logic [CTRL_W-1:0] ctrl_rdata, // control register value
  output logic protection_fault, // fault pulse
  output logic [15:0] fault_code, // fault error code
  input wire logic acc_valid, // core lookup
  input wire logic acc_write, // write lookup
  input wire logic acc_hit, // tag hit
  input wire logic [1:0] acc_state, // current line state
  input wire logic mtrr_allow, // range_memory_type_control permits
  input wire logic mtrr_off, // range control disabled
  input wire logic all_uncached, // all memory uncached
  input wire logic is_l1, // lookup targets first level
  input wire logic snoop_valid, // bus snoop
  input wire logic snoop_inv, // snoop asks invalidate
  input wire logic inval_instr, // invalidate_instruction
  input wire logic wbinval_instr, // writeback_invalidate_instruction
  output logic [1:0] mode, // current mode
  output logic rd_from_cache, // serve read from cache
  output logic allocate, // allocate line on miss
  output logic line_fill, // issue line fill
  output logic mem_write, // write reaches memory
  output logic rd_inval_cycle, // read invalidation cycle
  output logic state_we, // update line state
  output logic [1:0] state_new, // new line state
  output logic snoop_ack, // snoop answered
  output logic snoop_do_inv, // snoop invalidates line
  output logic flush_inv, // instruction invalidates
  output logic strict_order // strict ordering imposed
);
  comc_if fl ();
  comc_mode_t mode_c;
  logic cd, nw, rd_c, al_c, lf_c, mw_c, ri_c, sw_c, sa_c, si_c, fi_c, so_c;
  logic [1:0] sn_c;
  logic rd_r, al_r, lf_r, mw_r, ri_r, sw_r, sa_r, si_r, fi_r, so_r;
  logic [1:0] sn_r, md_r;

  function automatic comc_mode_t decode(input logic c, input logic n);
    unique case ({c, n})
      2'b00: decode = COMC_NORMAL;
      2'b01: decode = COMC_INVALID;
      2'b10: decode = COMC_NOFILL;
      2'b11: decode = COMC_NONCOH;
    endcase
  endfunction : decode

  comc_ctrl_reg u_reg (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(ctrl_wr),
    .wr_data(ctrl_wdata),
    .new_family(new_family),
    .ctrl_q(ctrl_rdata),
    .fault(protection_fault),
    .flags(fl.regs)
  );
  assign fault_code = FAULT_CODE;

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    cd = fl.cache_disable_flag;
    nw = fl.write_policy_flag;
    mode_c = decode(cd, nw);
    rd_c = 1'b0;
    al_c = 1'b0;
    lf_c = 1'b0;
    mw_c = 1'b0;
    ri_c = 1'b0;
    sw_c = 1'b0;
    sn_c = acc_state;
    sa_c = snoop_valid && !(mode_c == COMC_NONCOH && is_l1);
    si_c = snoop_valid && snoop_inv && mode_c != COMC_NONCOH;
    fi_c = inval_instr || wbinval_instr;
    so_c = cd && (mtrr_off || all_uncached);
    if (acc_valid) begin
      unique case (mode_c)
        COMC_NORMAL: begin
          rd_c = !acc_write && acc_hit;
          al_c = !acc_hit;
          lf_c = !acc_hit;
          if (acc_write && acc_hit && acc_state == ST_S) begin
            mw_c = 1'b1;
            ri_c = is_l1 && mtrr_allow;
            sw_c = is_l1 && mtrr_allow;
            sn_c = ST_M;
          end else if (acc_write && acc_hit && acc_state == ST_E) begin
            sw_c = 1'b1;
            sn_c = ST_M;
          end
        end
        COMC_NOFILL: begin
          rd_c = !acc_write && acc_hit;
          mw_c = acc_write && (!acc_hit || acc_state == ST_S);
          if (acc_write && acc_hit && acc_state == ST_S && mtrr_allow) begin
            ri_c = 1'b1;
            sw_c = 1'b1;
            sn_c = ST_E;
          end
        end
        COMC_NONCOH: begin
          rd_c = !acc_write && acc_hit;
          mw_c = acc_write && !acc_hit;
          if (acc_write && acc_hit && acc_state == ST_E) begin
            sw_c = 1'b1;
            sn_c = ST_M;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_r <= 1'b0;
      al_r <= 1'b0;
      lf_r <= 1'b0;
      mw_r <= 1'b0;
      ri_r <= 1'b0;
      sw_r <= 1'b0;
      sn_r <= 2'h0;
      sa_r <= 1'b0;
      si_r <= 1'b0;
      fi_r <= 1'b0;
      so_r <= 1'b0;
      md_r <= 2'h2;
    end else begin
      rd_r <= rd_c;
      al_r <= al_c;
      lf_r <= lf_c;
      mw_r <= mw_c;
      ri_r <= ri_c;
      sw_r <= sw_c;
      sn_r <= sn_c;
      sa_r <= sa_c;
      si_r <= si_c;
      fi_r <= fi_c;
      so_r <= so_c;
      md_r <= mode_c;
    end
  end

  assign rd_from_cache = rd_r;
  assign allocate = al_r;
  assign line_fill = lf_r;
  assign mem_write = mw_r;
  assign rd_inval_cycle = ri_r;
  assign state_we = sw_r;
  assign state_new = sn_r;
  assign snoop_ack = sa_r;
  assign snoop_do_inv = si_r;
  assign flush_inv = fi_r;
  assign strict_order = so_r;
  assign mode = md_r;

  //////////////////////////////////////////////////////////////////////
  sequence s_write_miss_normal;
    acc_valid && acc_write && !acc_hit && !ctrl_rdata[CD_BIT];
  endsequence

  chk_normal_fill: assert property (@(posedge clk) disable iff (sys_rst)
    s_write_miss_normal |=> line_fill && allocate)
    else $error("normal write miss did not fill");
  chk_nofill_alloc: assert property (@(posedge clk) disable iff (sys_rst)
    acc_valid && ctrl_rdata[CD_BIT] |=> !allocate && !line_fill)
    else $error("allocation while cache disabled");
  chk_snoop_answer: assert property (@(posedge clk) disable iff (sys_rst)
    snoop_valid && ctrl_rdata[CD_BIT] && !ctrl_rdata[NW_BIT] |=> snoop_ack)
    else $error("snoop dropped while disabled");
  chk_noncoh_snoop: assert property (@(posedge clk) disable iff (sys_rst)
    snoop_valid && !new_family && ctrl_rdata[CD_BIT] && ctrl_rdata[NW_BIT] |=> !snoop_do_inv)
    else $error("snoop invalidated in non-coherent mode");
  chk_shared_stays: assert property (@(posedge clk) disable iff (sys_rst)
    mode_c == COMC_NONCOH && acc_valid && acc_write && acc_state == ST_S |=> !state_we)
    else $error("shared line changed in non-coherent mode");
  chk_nofill_shared: assert property (@(posedge clk) disable iff (sys_rst)
    mode_c == COMC_NOFILL && acc_valid && acc_write && acc_hit && acc_state == ST_S && mtrr_allow
    |=> state_new == ST_E && rd_inval_cycle && mem_write)
    else $error("no-fill shared write hit wrong");
  // mode shows the invalid code during reset, flags one edge after release
  chk_reset_mode: assert property (@(posedge clk)
    $past(sys_rst) && !sys_rst && new_family |=> mode == COMC_NOFILL)
    else $error("reset did not give no-fill");
  chk_mode_follows: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl_wr && ctrl_wdata[CD_BIT] == 1'b0 && ctrl_wdata[NW_BIT] == 1'b0 |=> ##1 mode == COMC_NORMAL)
    else $error("mode did not follow flag write");

  sequence s_shared_hit_l1_normal;
    mode_c == COMC_NORMAL && acc_valid && acc_write && acc_hit && acc_state == ST_S && is_l1 && mtrr_allow;
  endsequence

  chk_normal_shared: assert property (@(posedge clk) disable iff (sys_rst)
    s_shared_hit_l1_normal |=> state_we && state_new == ST_M && rd_inval_cycle && mem_write)
    else $error("normal shared write hit wrong");
  chk_read_hit: assert property (@(posedge clk) disable iff (sys_rst)
    acc_valid && !acc_write && acc_hit && mode_c != COMC_INVALID |=> rd_from_cache)
    else $error("read hit not served from cache");
  chk_order_cached: assert property (@(posedge clk) disable iff (sys_rst)
    !ctrl_rdata[CD_BIT] |=> !strict_order)
    else $error("strict order while caching enabled");
  chk_flush_instr: assert property (@(posedge clk) disable iff (sys_rst)
    inval_instr || wbinval_instr |=> flush_inv)
    else $error("invalidate instruction ignored");
  chk_snoop_lower: assert property (@(posedge clk) disable iff (sys_rst)
    snoop_valid && !is_l1 |=> snoop_ack)
    else $error("lower level snoop dropped");
endmodule : comc_mode_ctrl

//--- verif/comc_snoop_agent.sv
// snoop agent on the system bus side of the cache mode block
// assumes requests from the bench arrive one cycle wide, launched after a clock edge
`timescale 1ns/1ps
module comc_snoop_agent (
  input wire logic clk, // core clock
  input wire logic sys_rst, // sync reset
  input wire logic req, // bench asks for one snoop
  input wire logic req_inv, // snoop wants invalidation
  output logic snoop_valid, // snoop to the cache
  output logic snoop_inv // invalidate qualifier
);
  // qualifier toggles when idle so a stale level never looks valid
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      snoop_valid <= 1'b0;
      snoop_inv <= 1'b0;
    end else begin
      snoop_valid <= req;
      snoop_inv <= req ? req_inv : ~snoop_inv;
    end
  end
endmodule : comc_snoop_agent

//--- verif/tb_top.sv
// self-checking bench for the cache operating mode control block
// assumes registered decisions one cycle after each lookup
`timescale 1ns/1ps
module tb_top;
  import comc_pkg::*;
  logic clk = 0, sys_rst = 1, new_family = 1, ctrl_wr = 0, acc_valid = 0, acc_write = 0, acc_hit = 0;
  logic [CTRL_W-1:0] ctrl_wdata = '0;
  logic [1:0] acc_state = 2'h0;
  logic mtrr_allow = 1, mtrr_off = 0, all_uncached = 0, is_l1 = 0, inval_instr = 0, wbinval_instr = 0;
  logic req = 0, req_inv = 0, snoop_valid, snoop_inv;
  logic [CTRL_W-1:0] ctrl_rdata;
  logic [15:0] fault_code;
  logic [1:0] mode, state_new;
  logic protection_fault, rd_from_cache, allocate, line_fill, mem_write, rd_inval_cycle, state_we;
  logic snoop_ack, snoop_do_inv, flush_inv, strict_order;
  int failures = 0, checks = 0, cyc = 0;
  always #4 clk = ~clk;
  comc_snoop_agent agent (.clk(clk), .sys_rst(sys_rst), .req(req), .req_inv(req_inv),
    .snoop_valid(snoop_valid), .snoop_inv(snoop_inv));
  comc_mode_ctrl dut (.clk(clk), .sys_rst(sys_rst), .new_family(new_family), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata), .protection_fault(protection_fault),
    .fault_code(fault_code), .acc_valid(acc_valid), .acc_write(acc_write), .acc_hit(acc_hit),
    .acc_state(acc_state), .mtrr_allow(mtrr_allow), .mtrr_off(mtrr_off), .all_uncached(all_uncached),
    .is_l1(is_l1), .snoop_valid(snoop_valid), .snoop_inv(snoop_inv), .inval_instr(inval_instr),
    .wbinval_instr(wbinval_instr), .mode(mode), .rd_from_cache(rd_from_cache), .allocate(allocate),
    .line_fill(line_fill), .mem_write(mem_write), .rd_inval_cycle(rd_inval_cycle), .state_we(state_we),
    .state_new(state_new), .snoop_ack(snoop_ack), .snoop_do_inv(snoop_do_inv), .flush_inv(flush_inv),
    .strict_order(strict_order));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task automatic stop_test;
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      failures++;
      stop_test();
    end
  end
  // write control register, return once the register holds the value
  task automatic wr_ctrl(input logic [CTRL_W-1:0] d);
    @(posedge clk);
    ctrl_wr <= 1'b1;
    ctrl_wdata <= d;
    @(posedge clk);
    ctrl_wr <= 1'b0;
    #1;
  endtask : wr_ctrl
  task automatic look(input logic w, input logic hit, input logic [1:0] st);
    @(posedge clk);
    acc_valid <= 1'b1;
    acc_write <= w;
    acc_hit <= hit;
    acc_state <= st;
    @(posedge clk);
    acc_valid <= 1'b0;
    #1;
  endtask : look
  task automatic snoop(input logic inv);
    @(posedge clk);
    req <= 1'b1;
    req_inv <= inv;
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
    #1;
  endtask : snoop
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(ctrl_rdata === CTRL_RST && mode === COMC_NOFILL, "reset state");
  endtask : t_reset
  task automatic t_invalid;
    wr_ctrl(32'h2000_0000);
    chk(protection_fault === 1'b1 && fault_code === FAULT_CODE, "no fault");
    @(posedge clk);
    #1;
    chk(ctrl_rdata === CTRL_RST && mode === COMC_NOFILL, "flags moved");
  endtask : t_invalid
  task automatic t_normal;
    wr_ctrl(32'h0000_0000);
    @(posedge clk);
    #1;
    chk(ctrl_rdata === 32'h0 && mode === COMC_NORMAL, "normal mode");
    look(0, 0, ST_I);
    chk(allocate === 1'b1, "read miss no alloc");
    look(0, 1, ST_E);
    chk(rd_from_cache === 1'b1, "read hit");
    look(1, 0, ST_I);
    chk(line_fill === 1'b1, "write miss no fill");
    look(1, 1, ST_E);
    chk(state_we === 1'b1 && state_new === ST_M && mem_write === 1'b0, "write hit E");
    is_l1 <= 1'b1;
    look(1, 1, ST_S);
    chk(state_new === ST_M && rd_inval_cycle === 1'b1 && mem_write === 1'b1 && state_we === 1'b1, "shared hit");
    is_l1 <= 1'b0;
    mtrr_off <= 1'b1;
    look(0, 1, ST_E);
    chk(strict_order === 1'b0, "order while cached");
    mtrr_off <= 1'b0;
  endtask : t_normal
  task automatic t_nofill;
    wr_ctrl(32'h4000_0000);
    @(posedge clk);
    inval_instr <= 1'b1;
    @(posedge clk);
    inval_instr <= 1'b0;
    #1;
    chk(flush_inv === 1'b1 && mode === COMC_NOFILL, "flush");
    look(0, 0, ST_I);
    chk(allocate === 1'b0 && line_fill === 1'b0, "nofill alloc");
    look(0, 1, ST_S);
    chk(rd_from_cache === 1'b1, "nofill read hit");
    look(1, 0, ST_I);
    chk(mem_write === 1'b1 && allocate === 1'b0, "nofill write miss");
    look(1, 1, ST_S);
    chk(state_new === ST_E && rd_inval_cycle === 1'b1 && mem_write === 1'b1, "nofill shared");
    mtrr_allow <= 1'b0;
    look(1, 1, ST_S);
    chk(state_we === 1'b0 && rd_inval_cycle === 1'b0 && mem_write === 1'b1, "nofill shared no range");
    mtrr_allow <= 1'b1;
    chk(strict_order === 1'b0, "order forced");
    mtrr_off <= 1'b1;
    look(0, 1, ST_E);
    chk(strict_order === 1'b1, "order lost");
    mtrr_off <= 1'b0;
    all_uncached <= 1'b1;
    look(0, 1, ST_E);
    chk(strict_order === 1'b1, "uncached order lost");
    all_uncached <= 1'b0;
    snoop(1);
    chk(snoop_ack === 1'b1 && snoop_do_inv === 1'b1, "snoop ignored");
  endtask : t_nofill
  task automatic t_noncoh;
    new_family <= 1'b0;
    wr_ctrl(32'h6000_0000);
    @(posedge clk);
    #1;
    chk(mode === COMC_NONCOH, "noncoh mode");
    look(1, 1, ST_E);
    chk(state_new === ST_M && state_we === 1'b1, "E to M");
    look(1, 1, ST_S);
    chk(state_we === 1'b0 || state_new === ST_S, "S changed");
    look(1, 0, ST_I);
    chk(mem_write === 1'b1 && allocate === 1'b0, "noncoh miss");
    is_l1 <= 1'b1;
    snoop(1);
    chk(snoop_do_inv === 1'b0 && snoop_ack === 1'b0, "snoop acted");
    is_l1 <= 1'b0;
    snoop(1);
    chk(snoop_ack === 1'b1 && snoop_do_inv === 1'b0, "lower level snoop");
    @(posedge clk);
    wbinval_instr <= 1'b1;
    @(posedge clk);
    wbinval_instr <= 1'b0;
    #1;
    chk(flush_inv === 1'b1, "wbinval");
  endtask : t_noncoh
  task automatic t_rerun;
    new_family <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(ctrl_rdata === CTRL_RST && mode === COMC_NOFILL && snoop_ack === 1'b0, "mid-run reset");
  endtask : t_rerun
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_invalid();
    t_normal();
    t_nofill();
    t_noncoh();
    t_rerun();
    stop_test();
  end
endmodule : tb_top
